// file: core/hiem_pkg.sv
/*
 * constants for the host interrupt enable mask block: register offsets,
 * bit positions, access masks and reset values.
 * assumes a 32-bit apb bus with byte addresses and one word per register.
 */
// Operation
// R01 - bit 15 enables link change interrupt; resets to 0, read-write
// R02 - bit 14 enables frame transmitted interrupt; resets to 0, read-write
// R03 - bit 13 enables frame received interrupt; resets to 0, read-write
// R04 - bit 11 enables receive overrun interrupt; resets to 0, read-write
// R05 - bit 12 read-only, reset 0, or of per-unit time stamp enables; the code ors each unit enable anded with its unit flag
// R06 - time stamp summary falls when unit enable or unit flag clears
// R07 - bit 10 read-only, reset 0, or of per-unit trigger enables; the code ors each unit enable anded with its unit flag
// R08 - trigger summary falls when unit enable or unit flag clears
// R09 - host software writes zero into bits 12 and 10
// R10 - bit 9 enables transmit stopped interrupt; resets to 0, read-write
// R11 - bit 8 enables receive stopped interrupt; resets to 0, read-write
// R12 - bit 6 enables transmit space available interrupt; reset 0, read-write
// R13 - bit 5 enables wake-up frame interrupt; resets to 0, read-write
// R14 - bit 4 enables magic packet interrupt; resets to 0, read-write
// R15 - bit 3 enables link-up wake interrupt; resets to 0, read-write
// R16 - bit 2 enables energy detect wake interrupt; resets to 0, read-write
// R17 - interrupt output high while any flag and its enable are set
// R18 - flags survive reads; writing one clears; device holds flag until then
// R19 - bit 7 stored read-write reset 0; bits 1 to 0 read zero
package hiem_pkg;

    // bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W  = 16;
    localparam int STRB_W = DATA_W / 8;

    // default number of ptp time stamp and trigger units
    localparam int PTP_UNITS = 12;

    // register byte addresses
    localparam logic [ADDR_W-1:0] IEM_ADDR   = 12'h190;
    localparam logic [ADDR_W-1:0] FLAGS_ADDR = 12'h194;
    localparam logic [ADDR_W-1:0] CLEAR_ADDR = 12'h198;

    // bit positions, shared by the enable, flag and clear registers
    localparam int LINK_CHANGE_BIT = 15;
    localparam int TX_DONE_BIT     = 14;
    localparam int RX_FRAME_BIT    = 13;
    localparam int TS_SUM_BIT      = 12;
    localparam int RX_OVERRUN_BIT  = 11;
    localparam int TRIG_SUM_BIT    = 10;
    localparam int TX_STOPPED_BIT  = 9;
    localparam int RX_STOPPED_BIT  = 8;
    localparam int SPARE_BIT       = 7;
    localparam int TX_SPACE_BIT    = 6;
    localparam int WAKE_FRAME_BIT  = 5;
    localparam int MAGIC_BIT       = 4;
    localparam int LINKUP_BIT      = 3;
    localparam int ENERGY_BIT      = 2;

    // writable enable bits: all but 12, 10, 1 and 0
    localparam logic [REG_W-1:0] IEM_RW_MASK = 16'hebfc;
    // flag bits that an event can set: all but 7, 1 and 0
    localparam logic [REG_W-1:0] FLAG_MASK   = 16'hff7c;
    localparam logic [REG_W-1:0] IEM_RESET   = 16'h0000;
    localparam logic [REG_W-1:0] FLAG_RESET  = 16'h0000;
    localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

    typedef logic [REG_W-1:0] hiem_word_t;

endpackage

// file: core/hiem_flag_if.sv
/*
 * carrier between the register front end and the sticky flag bank:
 * set and clear vectors in, flag vector out.
 * assumes both ends run on the same pclk.
 */
`timescale 1ns/1ps
`default_nettype none

interface hiem_flag_if #(
    parameter int W = 16
);
    logic [W-1:0] set;   // one-cycle event pulses
    logic [W-1:0] clr;   // one-cycle write-one-to-clear pulses
    logic [W-1:0] flag;  // sticky flags

    // the bank keeps the flags
    modport owner (
        input  set,
        input  clr,
        output flag
    );

    // the register front end drives events and clears
    modport user (
        output set,
        output clr,
        input  flag
    );
endinterface

`default_nettype wire

// file: core/hiem_flag_bank.sv
/*
 * bank of sticky interrupt flags, one per bit of the carrier.
 * assumes set and clr are one-cycle pulses synchronous to pclk.
 */
`timescale 1ns/1ps
`default_nettype none

module hiem_flag_bank
    import hiem_pkg::*;
#(
    parameter int         W     = REG_W,
    parameter logic [W-1:0] RESET = '0
) (
    input  wire logic  pclk,
    input  wire logic  presetn,
    hiem_flag_if.owner flags
);

    typedef struct packed {
        logic [W-1:0] flag;
    } hiem_bank_s;

    hiem_bank_s state;
    hiem_bank_s next_state;

    // a set in the same cycle as its clear wins, so no event is lost
    always_comb begin
        next_state      = state;
        next_state.flag = (state.flag & ~flags.clr) | flags.set; // R18
    end

    // flags hold through reads; only a clear pulse drops them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '{flag: RESET};
        end else begin
            state <= next_state;
        end
    end

    assign flags.flag = state.flag;

endmodule

`default_nettype wire

// file: core/hiem_top.sv
/*
 * host interrupt enable mask: apb slave holding the enable register,
 * a read-only sticky flag register and a write-only clear register,
 * with the two ptp summary enables and the level host interrupt.
 * assumes event pulses and ptp per-unit vectors are synchronous to pclk;
 * the ptp per-unit registers themselves live outside this block.
 */
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none

module hiem_top
    import hiem_pkg::*;
#(
    parameter int UNITS = PTP_UNITS
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    input  wire logic [STRB_W-1:0] pstrb,
    output var  logic [DATA_W-1:0] prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    input  wire logic [REG_W-1:0]  event_pulse,
    input  wire logic [UNITS-1:0]  timestamp_unit_enables,
    input  wire logic [UNITS-1:0]  timestamp_unit_flags,
    input  wire logic [UNITS-1:0]  trigger_unit_enables,
    input  wire logic [UNITS-1:0]  trigger_unit_flags,
    output var  logic [REG_W-1:0]  interrupt_enable_mask,
    output var  logic              host_irq
);

    // the summary or-trees are sized for up to one word of units
    if (UNITS < 1 || UNITS > DATA_W) begin : g_bad_units
        $error("hiem_top: UNITS must lie between 1 and 32");
    end

    typedef struct packed {
        hiem_word_t        enables;  // writable enable bits only
        logic              ts_sum;   // time stamp summary enable
        logic              trig_sum; // trigger summary enable
        logic [DATA_W-1:0] rdata;    // read data captured in setup
        logic              irq;      // registered host interrupt
    } hiem_top_s;

    hiem_top_s state;
    hiem_top_s next_state;

    hiem_flag_if #(.W(REG_W)) flag_bus ();

    hiem_flag_bank #(
        .W     (REG_W),
        .RESET (FLAG_RESET)
    ) u_flags (
        .pclk    (pclk),
        .presetn (presetn),
        .flags   (flag_bus)
    );

    // apb phase decode
    logic       setup_phase;
    logic       access_phase;
    logic       hit_iem;
    logic       hit_flags;
    logic       hit_clear;
    logic       mapped;
    hiem_word_t lane_mask;
    hiem_word_t enable_view;

    always_comb begin
        setup_phase  = psel & ~penable;
        access_phase = psel & penable;
        hit_iem      = (paddr == IEM_ADDR);
        hit_flags    = (paddr == FLAGS_ADDR);
        hit_clear    = (paddr == CLEAR_ADDR);
        mapped       = hit_iem | hit_flags | hit_clear;
    end

    // only the two low byte lanes carry register bits
    assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    // zero wait states: read data was captured in the setup cycle
    assign pready  = access_phase;
    // unmapped addresses are refused; the write is dropped
    assign pslverr = access_phase & ~mapped;

    // the register as software sees it: stored bits plus summaries,
    // bits 1 to 0 never stored so they always read zero
    always_comb begin
        enable_view               = state.enables;
        enable_view[TS_SUM_BIT]   = state.ts_sum;    // R05
        enable_view[TRIG_SUM_BIT] = state.trig_sum;  // R07
    end

    // events enter the bank only at positions that own a flag
    assign flag_bus.set = event_pulse & FLAG_MASK;

    // write-one-to-clear, honoured only at the completing access edge
    assign flag_bus.clr = (access_phase & pwrite & hit_clear)
                        ? (pwdata[REG_W-1:0] & lane_mask & FLAG_MASK)
                        : '0; // R18

    // next state of the front end
    always_comb begin
        next_state = state;

        // enable write: read-only summary positions and bits 1 to 0
        // are masked off, so a stray one there has no effect
        if (access_phase & pwrite & hit_iem) begin
            next_state.enables = (state.enables & ~lane_mask)
                | (pwdata[REG_W-1:0] & lane_mask & IEM_RW_MASK); // R09
            // each line below is covered by the masked update above
            // R01 R02 R03 R04 R10 R11 R12 R13 R14 R15 R16 R19
        end

        // summaries are and-or of unit enable with unit flag, so a
        // clear of either one drops the bit on the next edge
        next_state.ts_sum =
            |(timestamp_unit_enables & timestamp_unit_flags); // R06
        next_state.trig_sum =
            |(trigger_unit_enables & trigger_unit_flags); // R08

        // capture read data in setup; it stands through the access
        if (setup_phase & ~pwrite) begin
            if (hit_iem) begin
                next_state.rdata = {{(DATA_W-REG_W){1'b0}}, enable_view};
            end else if (hit_flags) begin
                // reading leaves the flags untouched
                next_state.rdata = {{(DATA_W-REG_W){1'b0}},
                                    flag_bus.flag}; // R18
            end else begin
                // clear register is write-only; unmapped reads zero
                next_state.rdata = RDATA_RESET;
            end
        end

        // level interrupt while any enabled flag stands
        next_state.irq = |(flag_bus.flag & enable_view); // R17
    end

    // single register stage for all front-end state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '{enables:  IEM_RESET,
                       ts_sum:   1'b0,
                       trig_sum: 1'b0,
                       rdata:    RDATA_RESET,
                       irq:      1'b0};
        end else begin
            state <= next_state;
        end
    end

    // outputs straight from flops
    assign prdata                = state.rdata;
    assign interrupt_enable_mask = enable_view;
    assign host_irq              = state.irq;

endmodule

`default_nettype wire

// file: test/hiem_top_checker.sv
/* checker for hiem_top: enable view, ptp summaries, host interrupt.
   assumes it is bound into hiem_top and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module hiem_top_checker
    import hiem_pkg::*;
#(
    parameter int UNITS = PTP_UNITS
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [STRB_W-1:0] pstrb,
    input wire logic [REG_W-1:0]  event_pulse,
    input wire logic [UNITS-1:0]  timestamp_unit_enables,
    input wire logic [UNITS-1:0]  timestamp_unit_flags,
    input wire logic [UNITS-1:0]  trigger_unit_enables,
    input wire logic [UNITS-1:0]  trigger_unit_flags,
    input wire logic [REG_W-1:0]  interrupt_enable_mask,
    input wire logic              host_irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // short names; wr marks an enable write in its access cycle
    logic [REG_W-1:0] m;
    logic             ts, tr, wr;
    assign m  = interrupt_enable_mask;
    assign ts = |(timestamp_unit_enables & timestamp_unit_flags);
    assign tr = |(trigger_unit_enables & trigger_unit_flags);
    assign wr = psel && penable && pwrite && paddr == IEM_ADDR;
    // summaries follow their unit pairs one edge later
    property p_ts_on; ts |=> m[TS_SUM_BIT]; endproperty
    property p_ts_off; !ts |=> !m[TS_SUM_BIT]; endproperty
    property p_tr_on; tr |=> m[TRIG_SUM_BIT]; endproperty
    property p_tr_off; !tr |=> !m[TRIG_SUM_BIT]; endproperty
    a_ts_on: assert property (p_ts_on) else $error("ts summary low");
    a_ts_off: assert property (p_ts_off) else $error("ts summary high");
    a_tr_on: assert property (p_tr_on) else $error("trig summary low");
    a_tr_off: assert property (p_tr_off) else $error("trig sum high");
    // written lanes land; summary bits are never taken from the bus
    property p_wr_hi;
        wr && pstrb[1] |=> (m[15:8] & 8'heb) == ($past(pwdata[15:8]) & 8'heb);
    endproperty
    property p_wr_lo;
        wr && pstrb[0] |=> m[7:2] == $past(pwdata[7:2]);
    endproperty
    property p_zero; m[1:0] == 2'b00; endproperty
    property p_irq;
        event_pulse[LINK_CHANGE_BIT] && m[15] ##1 m[15] |=> host_irq;
    endproperty
    a_wr_hi: assert property (p_wr_hi) else $error("high byte lost");
    a_wr_lo: assert property (p_wr_lo) else $error("low byte lost");
    a_zero: assert property (p_zero) else $error("bits 1:0 set");
    a_irq: assert property (p_irq) else $error("irq missing");
    c_wr: cover property (wr);
    c_irq: cover property ($rose(host_irq));
    c_sum: cover property ($fell(m[TS_SUM_BIT]));
endmodule
bind hiem_top hiem_top_checker #(.UNITS(UNITS)) chk (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .event_pulse,
    .timestamp_unit_enables, .timestamp_unit_flags, .trigger_unit_enables,
    .trigger_unit_flags, .interrupt_enable_mask, .host_irq);
`default_nettype wire

// file: test/hiem_host_model.sv
/* apb host model; the bench calls its transfer task.
   assumes one pclk; waits for pready, bounded, flags a hang. */
`timescale 1ns/1ps
`default_nettype none
module hiem_host_model
    import hiem_pkg::*;
(
    input  wire logic              pclk,
    output var  logic              psel,
    output var  logic              penable,
    output var  logic              pwrite,
    output var  logic [ADDR_W-1:0] paddr,
    output var  logic [DATA_W-1:0] pwdata,
    output var  logic [STRB_W-1:0] pstrb,
    input  wire logic [DATA_W-1:0] prdata,
    input  wire logic              pready,
    input  wire logic              pslverr
);
    logic hung = 1'b0;
    // idle bus from time zero
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    end
    // request held until pready is seen high at an edge
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, input logic [3:0] s,
                        output logic [DATA_W-1:0] q, output logic e);
        int n;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        // summary positions go out as zero only on an enable write,
        // so the clear register can still drop flags 12 and 10
        pwdata <= (a == IEM_ADDR) ? (d & ~32'h0000_1400) : d;
        pstrb  <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        hung = hung | (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: test/hiem_top_tb.sv
/* bench for hiem_top: registers, event masking, ptp summaries.
   assumes hiem_pkg, the host model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin num_checks++; if ((g) !== (x)) begin error_cnt++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, x); end end
module hiem_top_tb
    import hiem_pkg::*;
;
    logic              pclk = 1'b0;
    logic              presetn, psel, penable, pwrite, pready, pslverr;
    logic              host_irq, err;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic [STRB_W-1:0] pstrb;
    logic [REG_W-1:0]  event_pulse, iem;
    logic [11:0]       ts_en, ts_fl, tr_en, tr_fl;
    int                error_cnt = 0;
    int                num_checks = 0;
    int                srcs[11] = '{15, 14, 13, 11, 9, 8, 6, 5, 4, 3, 2};
    // ts enables, ts flags, trig enables, trig flags, bits 12 and 10
    logic [49:0]       tab[5] = '{
        {12'h800, 12'h800, 12'h001, 12'h001, 2'b11},
        {12'h800, 12'h000, 12'h000, 12'h001, 2'b00},
        {12'h001, 12'h800, 12'h001, 12'h002, 2'b00},
        {12'h800, 12'h800, 12'h001, 12'h001, 2'b11},
        {12'h000, 12'h800, 12'h001, 12'h000, 2'b00}};
    always #50 pclk = ~pclk;
    hiem_host_model host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr);
    hiem_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .event_pulse, .host_irq,
        .timestamp_unit_enables(ts_en), .timestamp_unit_flags(ts_fl),
        .trigger_unit_enables(tr_en), .trigger_unit_flags(tr_fl),
        .interrupt_enable_mask(iem));
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // a hung bus ends the run at once
    task automatic rw(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d, input logic [3:0] s);
        host.xfer(w, a, d, s, rd, err);
        if (host.hung) begin
            error_cnt++;
            close_out();
        end
    endtask
    task automatic settle();
        repeat (2) @(posedge pclk);
        #1;
    endtask
    task automatic pulse(input int b);
        @(posedge pclk);
        event_pulse <= 16'h1 << b;
        @(posedge pclk);
        event_pulse <= '0;
        settle();
    endtask
    task automatic t_reset();
        rw(1'b0, IEM_ADDR, '0, 4'h0);
        `CHK(rd, RDATA_RESET)
        rw(1'b0, FLAGS_ADDR, '0, 4'h0);
        `CHK(rd, RDATA_RESET)
    endtask
    // all ones, then the low lane cleared alone
    task automatic t_rw();
        rw(1'b1, IEM_ADDR, 32'hffff_ffff, 4'hf);
        rw(1'b0, IEM_ADDR, '0, 4'h0);
        `CHK(rd, 32'h0000_ebfc)
        rw(1'b1, IEM_ADDR, '0, 4'h1);
        #1;
        `CHK(iem, 16'heb00)
    endtask
    // unmapped write must not leak into the enable register
    task automatic t_bad();
        rw(1'b1, 12'h1a0, '0, 4'hf);
        `CHK(err, 1'b1)
        rw(1'b0, IEM_ADDR, '0, 4'h0);
        `CHK(rd, 32'h0000_eb00)
        rw(1'b0, CLEAR_ADDR, '0, 4'h0);
        `CHK(rd, RDATA_RESET)
        `CHK(err, 1'b0)
    endtask
    // each source masked, enabled late, read twice, cleared
    task automatic t_irq();
        foreach (srcs[i]) begin
            rw(1'b1, IEM_ADDR, '0, 4'h3);
            pulse(srcs[i]);
            `CHK(host_irq, 1'b0)
            rw(1'b0, FLAGS_ADDR, '0, 4'h0);
            rw(1'b0, FLAGS_ADDR, '0, 4'h0);
            `CHK(rd[srcs[i]], 1'b1)
            rw(1'b1, IEM_ADDR, 32'h1 << srcs[i], 4'h3);
            settle();
            `CHK(host_irq, 1'b1)
            rw(1'b1, CLEAR_ADDR, 32'h1 << srcs[i], 4'h3);
            pulse(srcs[i]);
            `CHK(host_irq, 1'b1)
            rw(1'b1, CLEAR_ADDR, 32'h1 << srcs[i], 4'h3);
            settle();
            `CHK(host_irq, 1'b0)
        end
    endtask
    task automatic t_ptp();
        foreach (tab[i]) begin
            @(posedge pclk);
            {ts_en, ts_fl, tr_en, tr_fl} <= tab[i][49:2];
            settle();
            `CHK({iem[TS_SUM_BIT], iem[TRIG_SUM_BIT]}, tab[i][1:0])
        end
    endtask
    // the summary bit is the enable of flag 12; its drop masks the flag
    task automatic t_sum();
        @(posedge pclk);
        {ts_en, ts_fl} <= {12'h004, 12'h004};
        pulse(TS_SUM_BIT);
        `CHK(host_irq, 1'b1)
        @(posedge pclk);
        ts_fl <= '0;
        settle();
        `CHK(host_irq, 1'b0)
        rw(1'b0, FLAGS_ADDR, '0, 4'h0);
        `CHK(rd, 32'h0000_1000)
        rw(1'b1, CLEAR_ADDR, 32'h1 << TS_SUM_BIT, 4'h3);
        rw(1'b0, FLAGS_ADDR, '0, 4'h0);
        `CHK(rd, RDATA_RESET)
    endtask
    // reset for two cycles, then the scenarios
    initial begin
        presetn = 1'b0;
        event_pulse = '0;
        {ts_en, ts_fl, tr_en, tr_fl} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_rw();
        t_bad();
        t_irq();
        t_ptp();
        t_sum();
        close_out();
    end
endmodule
`default_nettype wire
